// >>> src/tracker_consts.svh
`ifndef TRACKER_CONSTS_SVH
`define TRACKER_CONSTS_SVH
`define NUM_ENTRIES      4
`define ENTRY_IDX_W      2
`define NUM_ROUTES       4
`define ROUTE_IDX_W      2
`define CHAN_SLOTS       4
`define TAG_W            16
`define CHAN_W           16
`define ROUTE_ID_W       32
`define UNIQUE_ID_W      64
`define CODE_W           8
`define RC_SUCCESS       8'h00
`define RC_FAILED        8'hFE
`define RC_INVALID_PARAM 8'hFF
`define MSG_BYTE_W       8
`define SUBST_FIRST      3'h4
`define SUBST_LAST       3'h7
`define SUBST_BASE       4
`endif

// >>> src/tracker_pkg.sv
package tracker_pkg;
`include "tracker_consts.svh"
  typedef enum logic [0:0] {
    XFER_READ,
    XFER_WRITE
  } xfer_kind_t;
  typedef struct packed {
    logic                         used;
    logic [`TAG_W-1:0]            tag;
    logic [`ROUTE_ID_W-1:0]       route;
    logic [`CHAN_SLOTS-1:0]       chan_valid;
    logic [`CHAN_SLOTS-1:0][`CHAN_W-1:0] chans;
  } xfer_entry_t;
endpackage : tracker_pkg

// >>> src/route_xlate.sv
`timescale 1ns/100ps
`include "tracker_consts.svh"
// Combinational route table lookup in both directions; the table itself is loaded by
// the top module, since the configuration process that fills it is outside this block.
module route_xlate
  import tracker_pkg::*;
(
  input  wire logic [`NUM_ROUTES-1:0]                   route_valid,
  input  wire logic [`NUM_ROUTES-1:0][`ROUTE_ID_W-1:0]  route_ids,
  input  wire logic [`NUM_ROUTES-1:0][`UNIQUE_ID_W-1:0] route_uids,
  input  wire logic [`ROUTE_ID_W-1:0]                   find_route,
  output logic      [`UNIQUE_ID_W-1:0]                  found_uid,
  output logic                                          found_uid_ok,
  input  wire logic [`UNIQUE_ID_W-1:0]                  find_uid,
  output logic      [`ROUTE_ID_W-1:0]                   found_route,
  output logic                                          found_route_ok
);
  always_comb begin
    found_uid      = '0;
    found_uid_ok   = 1'b0;
    found_route    = '0;
    found_route_ok = 1'b0;
    for (int i = 0; i < `NUM_ROUTES; i++) begin
      if (route_valid[i] && route_ids[i] == find_route && !found_uid_ok) begin
        found_uid    = route_uids[i];
        found_uid_ok = 1'b1;
      end
      if (route_valid[i] && route_uids[i] == find_uid && !found_route_ok) begin
        found_route    = route_ids[i];
        found_route_ok = 1'b1;
      end
    end
  end
endmodule : route_xlate

// >>> src/transfer_completion_tracker.sv
`timescale 1ns/100ps
`include "tracker_consts.svh"
// Contract
// - Target read or write start creates an entry: tag, route id, channel list.
// - A finished read channel is searched for in the entry channel lists.
// - A finished write channel is searched for the same way.
// - With several channels left, only the finished one is removed, no report.
// - Last read channel done: report read completion and free the entry.
// - Last write channel done: report write completion and free the entry.
// - The report carries the stored tag.
// - The report carries the unique id found from the stored route id.
// - The report return code shows success or failure of the transfer.
// - Codes: 00h success, FEh failure, FFh invalid parameter.
// - Fast read sends data on a known channel with no message exchange.
// - After the last fast read byte, fast read completion is signalled.
// - Target write start requests a data-request message to the initiator.
// - Last write data byte received starts write-ended processing.
// - A quiesce message asks the protocol layer to abort related processes.
// - After quiesce, a response is sent carrying the quiesce return code.
// - With substitute flag, message bytes 4..7 become the route id for the uid.
// - A received route id is translated to a unique id on request.
module transfer_completion_tracker
  import tracker_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire logic                       route_load,
  input  wire logic [`ROUTE_IDX_W-1:0]    route_load_idx,
  input  wire logic [`ROUTE_ID_W-1:0]     route_load_id,
  input  wire logic [`UNIQUE_ID_W-1:0]    route_load_uid,
  input  wire logic                       start_req,
  input  wire logic                       start_kind,
  input  wire logic [`TAG_W-1:0]          start_tag,
  input  wire logic [`ROUTE_ID_W-1:0]     start_route,
  input  wire logic [`CHAN_SLOTS-1:0]     start_chan_valid,
  input  wire logic [`CHAN_SLOTS*`CHAN_W-1:0] start_channel_list,
  output logic                            start_ack,
  output logic                            start_full,
  output logic                            data_request_send,
  output logic [`TAG_W-1:0]               data_request_tag,
  output logic [`ROUTE_ID_W-1:0]          data_request_route,
  input  wire logic                       read_last_byte,
  input  wire logic                       write_last_byte,
  input  wire logic [`CHAN_W-1:0]         done_chan,
  input  wire logic                       done_failed,
  output logic                            read_done,
  output logic                            write_done,
  output logic [`TAG_W-1:0]               done_tag,
  output logic [`UNIQUE_ID_W-1:0]         done_uid,
  output logic [`CODE_W-1:0]              done_code,
  output logic                            no_match_err,
  input  wire logic                       fast_start,
  input  wire logic [`CHAN_W-1:0]         fast_chan,
  input  wire logic                       fast_last_byte,
  output logic                            fast_send,
  output logic [`CHAN_W-1:0]              fast_send_chan,
  output logic                            fast_done,
  input  wire logic                       quiesce_rx,
  output logic                            abort_req,
  input  wire logic                       abort_done,
  input  wire logic [`CODE_W-1:0]         abort_code,
  output logic                            response_send,
  output logic [`CODE_W-1:0]              response_code,
  input  wire logic                       msg_valid,
  input  wire logic [2:0]                 msg_byte_idx,
  input  wire logic [`MSG_BYTE_W-1:0]     msg_byte_in,
  input  wire logic                       substitute_path_flag,
  input  wire logic [`UNIQUE_ID_W-1:0]    msg_uid,
  output logic                            msg_out_valid,
  output logic [`MSG_BYTE_W-1:0]          msg_byte_out,
  input  wire logic                       uid_query,
  input  wire logic [`ROUTE_ID_W-1:0]     uid_query_route,
  output logic                            uid_answer,
  output logic [`UNIQUE_ID_W-1:0]         uid_answer_value,
  output logic [`CODE_W-1:0]              uid_answer_code
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    xfer_entry_t [`NUM_ENTRIES-1:0]               tbl;
    logic [`NUM_ROUTES-1:0]                       rt_valid;
    logic [`NUM_ROUTES-1:0][`ROUTE_ID_W-1:0]      rt_ids;
    logic [`NUM_ROUTES-1:0][`UNIQUE_ID_W-1:0]     rt_uids;
    logic                                         start_ack;
    logic                                         start_full;
    logic                                         dreq_send;
    logic [`TAG_W-1:0]                            dreq_tag;
    logic [`ROUTE_ID_W-1:0]                       dreq_route;
    logic                                         read_done;
    logic                                         write_done;
    logic [`TAG_W-1:0]                            done_tag;
    logic [`UNIQUE_ID_W-1:0]                      done_uid;
    logic [`CODE_W-1:0]                           done_code;
    logic                                         no_match;
    logic                                         fast_active;
    logic                                         fast_send;
    logic [`CHAN_W-1:0]                           fast_chan;
    logic                                         fast_done;
    logic                                         abort_req;
    logic                                         resp_send;
    logic [`CODE_W-1:0]                           resp_code;
    logic                                         msg_valid;
    logic [`MSG_BYTE_W-1:0]                       msg_byte;
    logic                                         uid_ans;
    logic [`UNIQUE_ID_W-1:0]                      uid_val;
    logic [`CODE_W-1:0]                           uid_code;
    logic                                         query_pend;
    logic [`ROUTE_ID_W-1:0]                       query_route;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [`UNIQUE_ID_W-1:0] lk_uid;
  logic                    lk_uid_ok;
  logic [`ROUTE_ID_W-1:0]  lk_route;
  logic                    lk_route_ok;
  logic [`ROUTE_ID_W-1:0]  lk_find_route;

  // ************************************************************
  // Route table lookup
  // ************************************************************
  route_xlate u_xlate (
    .route_valid    (st_r.rt_valid),
    .route_ids      (st_r.rt_ids),
    .route_uids     (st_r.rt_uids),
    .find_route     (lk_find_route),
    .found_uid      (lk_uid),
    .found_uid_ok   (lk_uid_ok),
    .find_uid       (msg_uid),
    .found_route    (lk_route),
    .found_route_ok (lk_route_ok)
  );

  // ************************************************************
  // Channel match per entry and slot
  // ************************************************************
  logic [`NUM_ENTRIES-1:0][`CHAN_SLOTS-1:0] hit;
  logic [`NUM_ENTRIES-1:0]                  hit_any;
  logic [`NUM_ENTRIES-1:0]                  last_one;

  genvar ge, gs;
  generate
    for (ge = 0; ge < `NUM_ENTRIES; ge++) begin : g_ent
      for (gs = 0; gs < `CHAN_SLOTS; gs++) begin : g_slot
        assign hit[ge][gs] = st_r.tbl[ge].used && st_r.tbl[ge].chan_valid[gs]
                             && st_r.tbl[ge].chans[gs] == done_chan;
      end
      assign hit_any[ge]  = |hit[ge];
      assign last_one[ge] = (st_r.tbl[ge].chan_valid & ~hit[ge]) == '0;
    end
  endgenerate

  // First hit entry and first free entry; lowest index wins.
  logic                    found;
  logic [`ENTRY_IDX_W-1:0] found_idx;
  logic                    free_ok;
  logic [`ENTRY_IDX_W-1:0] free_idx;
  always_comb begin
    found     = 1'b0;
    found_idx = '0;
    free_ok   = 1'b0;
    free_idx  = '0;
    for (int i = 0; i < `NUM_ENTRIES; i++) begin
      if (hit_any[i] && !found) begin
        found     = 1'b1;
        found_idx = `ENTRY_IDX_W'(i);
      end
      if (!st_r.tbl[i].used && !free_ok) begin
        free_ok  = 1'b1;
        free_idx = `ENTRY_IDX_W'(i);
      end
    end
  end

  // The completion lookup and a protocol-layer query share one translator port;
  // a matched completion has priority, so a query in the same cycle is answered late by one.
  // The deferred query keeps its own copy of the route id, so the caller may move on.
  logic done_ev;
  logic query_go;
  assign done_ev       = read_last_byte || write_last_byte;
  assign query_go      = uid_query && !(done_ev && found);
  assign lk_find_route = (done_ev && found) ? st_r.tbl[found_idx].route
                       : st_r.query_pend ? st_r.query_route : uid_query_route;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.start_ack  = 1'b0;
    st_nxt.dreq_send  = 1'b0;
    st_nxt.read_done  = 1'b0;
    st_nxt.write_done = 1'b0;
    st_nxt.no_match   = 1'b0;
    st_nxt.fast_done  = 1'b0;
    st_nxt.resp_send  = 1'b0;
    st_nxt.uid_ans    = 1'b0;
    st_nxt.query_pend = st_r.query_pend && done_ev && found;

    if (route_load) begin
      st_nxt.rt_valid[route_load_idx] = 1'b1;
      st_nxt.rt_ids[route_load_idx]   = route_load_id;
      st_nxt.rt_uids[route_load_idx]  = route_load_uid;
    end

    // Completion of a read or write channel.
    if (done_ev) begin
      if (!found) begin
        st_nxt.no_match = 1'b1;
      end else if (!last_one[found_idx]) begin
        st_nxt.tbl[found_idx].chan_valid = st_r.tbl[found_idx].chan_valid
                                           & ~hit[found_idx];
      end else begin
        st_nxt.tbl[found_idx].used       = 1'b0;
        st_nxt.tbl[found_idx].chan_valid = '0;
        st_nxt.read_done  = read_last_byte;
        st_nxt.write_done = write_last_byte && !read_last_byte;
        st_nxt.done_tag   = st_r.tbl[found_idx].tag;
        st_nxt.done_uid   = lk_uid;
        st_nxt.done_code  = (done_failed || !lk_uid_ok) ? `RC_FAILED
                                                        : `RC_SUCCESS;
      end
    end

    // New entry; a slot freed this same cycle is reused only on the next one.
    st_nxt.start_full = !free_ok;
    if (start_req && free_ok) begin
      st_nxt.tbl[free_idx].used       = 1'b1;
      st_nxt.tbl[free_idx].tag        = start_tag;
      st_nxt.tbl[free_idx].route      = start_route;
      st_nxt.tbl[free_idx].chan_valid = start_chan_valid;
      st_nxt.tbl[free_idx].chans      = start_channel_list;
      st_nxt.start_ack = 1'b1;
      if (start_kind == XFER_WRITE) begin
        st_nxt.dreq_send  = 1'b1;
        st_nxt.dreq_tag   = start_tag;
        st_nxt.dreq_route = start_route;
      end
    end

    // Fast read: data goes straight out on the known channel.
    if (fast_start && !st_r.fast_active) begin
      st_nxt.fast_active = 1'b1;
      st_nxt.fast_send   = 1'b1;
      st_nxt.fast_chan   = fast_chan;
    end else if (st_r.fast_active && fast_last_byte) begin
      st_nxt.fast_active = 1'b0;
      st_nxt.fast_send   = 1'b0;
      st_nxt.fast_done   = 1'b1;
    end

    // Quiesce: hold the abort request until the protocol layer answers.
    if (quiesce_rx) begin
      st_nxt.abort_req = 1'b1;
    end else if (st_r.abort_req && abort_done) begin
      st_nxt.abort_req = 1'b0;
      st_nxt.resp_send = 1'b1;
      st_nxt.resp_code = abort_code;
    end

    // Outgoing message bytes, with optional route id substitution.
    st_nxt.msg_valid = msg_valid;
    st_nxt.msg_byte  = msg_byte_in;
    if (msg_valid && substitute_path_flag && msg_byte_idx >= `SUBST_FIRST
        && msg_byte_idx <= `SUBST_LAST) begin
      // Byte 4 carries the most significant byte of the route id.
      st_nxt.msg_byte = lk_route[(`SUBST_LAST - msg_byte_idx) * `MSG_BYTE_W
                                 +: `MSG_BYTE_W];
    end

    // Route id to unique id query.
    if ((uid_query && query_go) || (st_r.query_pend && !(done_ev && found))) begin
      st_nxt.uid_ans  = 1'b1;
      st_nxt.uid_val  = lk_uid_ok ? lk_uid : '0;
      st_nxt.uid_code = lk_uid_ok ? `RC_SUCCESS : `RC_FAILED;
    end else if (uid_query) begin
      st_nxt.query_pend  = 1'b1;
      st_nxt.query_route = uid_query_route;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign start_ack          = st_r.start_ack;
  assign start_full         = st_r.start_full;
  assign data_request_send  = st_r.dreq_send;
  assign data_request_tag   = st_r.dreq_tag;
  assign data_request_route = st_r.dreq_route;
  assign read_done          = st_r.read_done;
  assign write_done         = st_r.write_done;
  assign done_tag           = st_r.done_tag;
  assign done_uid           = st_r.done_uid;
  assign done_code          = st_r.done_code;
  assign no_match_err       = st_r.no_match;
  assign fast_send          = st_r.fast_send;
  assign fast_send_chan     = st_r.fast_chan;
  assign fast_done          = st_r.fast_done;
  assign abort_req          = st_r.abort_req;
  assign response_send      = st_r.resp_send;
  assign response_code      = st_r.resp_code;
  assign msg_out_valid      = st_r.msg_valid;
  assign msg_byte_out       = st_r.msg_byte;
  assign uid_answer         = st_r.uid_ans;
  assign uid_answer_value   = st_r.uid_val;
  assign uid_answer_code    = st_r.uid_code;
endmodule : transfer_completion_tracker

// >>> bench/tracker_partner.sv
`timescale 1ns/100ps
// Protocol layer stand-in: answers abort requests after a chosen delay.
module tracker_partner
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       abort_req,
  input  wire logic       data_request_send,
  input  wire logic [3:0] delay,
  input  wire logic [7:0] code,
  output logic            abort_done = 0,
  output logic [7:0]      abort_code = 0,
  output int              owed = 0
);
  logic [3:0] cnt_r = 0;
  always @(posedge ref_clk) begin
    cnt_r <= abort_req ? cnt_r + 4'h1 : 4'h0;
    abort_done <= #1 abort_req && cnt_r == delay;
    // Outside the answer the code lines carry garbage, never the last value.
    abort_code <= #1 (abort_req && cnt_r == delay) ? code : ~code;
    if (!nrst) owed <= 0;
    else if (data_request_send) owed <= owed + 1;
  end
endmodule : tracker_partner

// >>> bench/tracker_asserts.sv
`timescale 1ns/100ps
`include "tracker_consts.svh"
module tracker_asserts
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        start_req,
  input wire logic        start_kind,
  input wire logic        start_ack,
  input wire logic        data_request_send,
  input wire logic        read_last_byte,
  input wire logic        write_last_byte,
  input wire logic        done_failed,
  input wire logic        read_done,
  input wire logic        write_done,
  input wire logic        fast_start,
  input wire logic        fast_last_byte,
  input wire logic        fast_send,
  input wire logic        fast_done,
  input wire logic        quiesce_rx,
  input wire logic        abort_req,
  input wire logic        abort_done,
  input wire logic        response_send,
  input wire logic        msg_valid,
  input wire logic        substitute_path_flag,
  input wire logic        msg_out_valid,
  input wire logic        uid_query,
  input wire logic        uid_answer,
  input wire logic [7:0]  done_code,
  input wire logic [7:0]  abort_code,
  input wire logic [7:0]  response_code,
  input wire logic [7:0]  msg_byte_in,
  input wire logic [7:0]  msg_byte_out,
  input wire logic [15:0] fast_chan,
  input wire logic [15:0] fast_send_chan,
  input wire logic [2:0]  msg_byte_idx
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence quiesce_seen; quiesce_rx && !abort_req; endsequence
  sequence abort_answered; abort_req && abort_done; endsequence
  start_cause_a: assert property (start_ack |-> $past(start_req))
    else $error("start ack without request");
  data_req_a: assert property (data_request_send |-> start_ack && $past(start_kind))
    else $error("data request without write start");
  read_cause_a: assert property (read_done |-> $past(read_last_byte))
    else $error("read done without read end");
  write_cause_a: assert property (write_done
    |-> $past(write_last_byte && !read_last_byte)) else $error("write done without write end");
  fail_code_a: assert property ((read_done || write_done) && $past(done_failed)
    |-> done_code == `RC_FAILED) else $error("failed transfer not reported");
  code_set_a: assert property ((read_done || write_done)
    |-> done_code inside {`RC_SUCCESS, `RC_FAILED}) else $error("bad done code");
  fast_begin_a: assert property (fast_start && !fast_send
    |=> fast_send && fast_send_chan == $past(fast_chan)) else $error("fast read not started");
  fast_end_a: assert property (fast_send && fast_last_byte |=> fast_done && !fast_send)
    else $error("fast read not ended");
  quiesce_abort_a: assert property (quiesce_seen |=> abort_req)
    else $error("quiesce without abort");
  quiesce_resp_a: assert property (abort_answered
    |=> response_send && !abort_req && response_code == $past(abort_code))
    else $error("quiesce response wrong");
  msg_pass_a: assert property (msg_valid && !(substitute_path_flag && msg_byte_idx[2])
    |=> msg_out_valid && msg_byte_out == $past(msg_byte_in)) else $error("message byte lost");
  uid_answer_a: assert property (uid_query |-> ##[1:2] uid_answer)
    else $error("uid query unanswered");
endmodule : tracker_asserts
bind transfer_completion_tracker tracker_asserts i_tracker_asserts (.*);

// >>> bench/transfer_completion_tracker_test.sv
`timescale 1ns/100ps
`include "tracker_consts.svh"
module transfer_completion_tracker_test import tracker_pkg::*;;
  logic ref_clk = 0, nrst = 0, route_load = 0, start_req = 0, start_kind = 0;
  logic read_last_byte = 0, write_last_byte = 0, done_failed = 0, fast_start = 0;
  logic fast_last_byte = 0, quiesce_rx = 0, msg_valid = 0, substitute_path_flag = 0;
  logic uid_query = 0;
  logic [1:0] route_load_idx = 0;
  logic [2:0] msg_byte_idx = 0;
  logic [3:0] start_chan_valid = 0, delay = 0;
  logic [7:0] msg_byte_in = 0, code = 0;
  logic [15:0] start_tag = 0, done_chan = 0, fast_chan = 0;
  logic [31:0] route_load_id = 0, start_route = 0, uid_query_route = 0;
  logic [63:0] route_load_uid = 0, start_channel_list = 0, msg_uid = 0;
  logic start_ack, start_full, data_request_send, read_done, write_done, no_match_err;
  logic fast_send, fast_done, abort_req, abort_done, response_send, msg_out_valid, uid_answer;
  logic [7:0] abort_code, done_code, response_code, msg_byte_out, uid_answer_code;
  logic [15:0] data_request_tag, done_tag, fast_send_chan;
  logic [31:0] data_request_route;
  logic [63:0] done_uid, uid_answer_value;
  int mismatches = 0, check_count = 0, owed, n, seed = 32'h69d2;
  logic [31:0] r_id[4];
  logic [63:0] r_uid[4];
  logic [15:0] m_tag[4];
  logic [31:0] m_rt[4];
  logic m_used[4] = '{0, 0, 0, 0};
  int m_ch[4][$];
  always #2 ref_clk = ~ref_clk;
  transfer_completion_tracker i_transfer_completion_tracker (.*);
  tracker_partner i_tracker_partner (.*);
  task automatic cyc;
    @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic chk(string s, logic [63:0] e, logic [63:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // Lowest loaded slot wins; {code, uid} with FE when the route is unknown.
  function automatic logic [71:0] lookup(logic [31:0] rt);
    for (int i = 0; i < 3; i++) if (r_id[i] === rt) return {8'h00, r_uid[i]};
    return {8'hFE, 64'h0};
  endfunction : lookup
  task automatic start(logic k, logic [15:0] t, logic [31:0] rt, logic [15:0] c, int cn);
    int e;
    e = -1;
    for (int i = 3; i >= 0; i--) if (!m_used[i]) e = i;
    start_req = 1;
    start_kind = k;
    start_tag = t;
    start_route = rt;
    for (int i = 0; i < 4; i++) start_chan_valid[i] = i < cn;
    for (int i = 0; i < cn; i++) start_channel_list[16*i +: 16] = c + i;
    cyc;
    start_req = 0;
    chk("start_ack", e >= 0, start_ack);
    chk("data_request_send", e >= 0 && k, data_request_send);
    if (e >= 0) begin
      m_used[e] = 1;
      m_tag[e] = t;
      m_rt[e] = rt;
      m_ch[e] = {};
      for (int i = 0; i < cn; i++) m_ch[e].push_back(c + i);
      if (k) chk("data_request_tag", t, data_request_tag);
      if (k) chk("data_request_route", rt, data_request_route);
    end
    cyc;
  endtask : start
  task automatic complete(logic rd, logic [15:0] c, logic f);
    int e, k;
    logic fin;
    logic [71:0] u;
    e = -1;
    fin = 0;
    for (int i = 3; i >= 0; i--)
      for (int j = 0; j < m_ch[i].size(); j++) if (m_used[i] && m_ch[i][j] == c) begin
        e = i;
        k = j;
      end
    read_last_byte = rd;
    write_last_byte = !rd;
    done_chan = c;
    done_failed = f;
    cyc;
    read_last_byte = 0;
    write_last_byte = 0;
    chk("no_match_err", e < 0, no_match_err);
    if (e >= 0) begin
      m_ch[e].delete(k);
      fin = m_ch[e].size() == 0;
    end
    chk("read_done", fin && rd, read_done);
    chk("write_done", fin && !rd, write_done);
    if (fin) begin
      m_used[e] = 0;
      u = lookup(m_rt[e]);
      chk("done_tag", m_tag[e], done_tag);
      if (u[71:64] == 0) chk("done_uid", u[63:0], done_uid);
      chk("done_code", f ? `RC_FAILED : u[71:64], done_code);
    end
    cyc;
  endtask : complete
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    nrst = 1;
    for (int i = 0; i < 3; i++) begin
      r_id[i] = {$random(seed)};
      r_id[i][1:0] = i;
      r_uid[i] = {$random(seed), $random(seed)};
      route_load = 1;
      route_load_idx = i;
      route_load_id = r_id[i];
      route_load_uid = r_uid[i];
      cyc;
    end
    route_load = 0;
    start(0, $random(seed), r_id[0], 16'h0100, 3);
    complete(1, 16'h0101, 0);
    complete(1, 16'h0100, 0);
    complete(1, 16'h0102, 0);
    start(1, $random(seed), r_id[1], 16'h0200, 1);
    complete(0, 16'h0200, 1);
    start(1, $random(seed), 32'hFFFF_FFFF, 16'h0300, 2);
    complete(0, 16'h0301, 0);
    complete(0, 16'h0300, 0);
    chk("owed", 2, owed);
    complete(1, 16'h0999, 0);
    for (int i = 0; i < 5; i++)
      start(i[0], $random(seed), r_id[i % 3], 16'h1000 + 16 * i, 4);
    chk("start_full", 1, start_full);
    for (int i = 0; i < 4; i++)
      for (int j = 3; j >= 0; j--) complete(!i[0], 16'h1000 + 16 * i + j, $random(seed));
    fast_chan = $random(seed);
    fast_start = 1;
    cyc;
    fast_start = 0;
    chk("fast_send", 1, fast_send);
    chk("fast_send_chan", fast_chan, fast_send_chan);
    chk("data_request_send", 0, data_request_send);
    cyc;
    fast_last_byte = 1;
    cyc;
    fast_last_byte = 0;
    chk("fast_done", 1, fast_done);
    chk("fast_send", 0, fast_send);
    for (int d = 0; d < 2; d++) begin
      delay = d * 5;
      code = d ? `RC_FAILED : `RC_SUCCESS;
      quiesce_rx = 1;
      cyc;
      quiesce_rx = 0;
      chk("abort_req", 1, abort_req);
      for (n = 0; n < 20 && response_send !== 1'b1; n++) cyc;
      if (n == 20) begin
        mismatches++;
        complete_run;
      end
      chk("response_code", code, response_code);
    end
    msg_uid = r_uid[1];
    msg_valid = 1;
    for (int f = 0; f < 2; f++)
      for (int i = 0; i < 8; i++) begin
        substitute_path_flag = f;
        msg_byte_idx = i;
        msg_byte_in = $random(seed);
        cyc;
        chk("msg_byte_out", (f && i > 3) ? r_id[1][8*(7-i) +: 8] : msg_byte_in,
            msg_byte_out);
      end
    msg_valid = 0;
    for (int i = 0; i < 2; i++) begin
      uid_query_route = i ? 32'hFFFF_FFFF : r_id[2];
      uid_query = 1;
      cyc;
      uid_query = 0;
      if (uid_answer !== 1'b1) cyc;
      chk("uid_answer", 1, uid_answer);
      chk("uid_answer_code", i ? `RC_FAILED : `RC_SUCCESS, uid_answer_code);
      if (i == 0) chk("uid_answer_value", r_uid[2], uid_answer_value);
      cyc;
    end
    // A query that meets a matched completion is answered one cycle later.
    start(0, $random(seed), r_id[2], 16'h0500, 1);
    uid_query_route = r_id[0];
    uid_query = 1;
    read_last_byte = 1;
    done_chan = 16'h0500;
    done_failed = 0;
    cyc;
    uid_query = 0;
    read_last_byte = 0;
    chk("read_done", 1, read_done);
    chk("done_uid", r_uid[2], done_uid);
    chk("uid_answer", 0, uid_answer);
    cyc;
    chk("uid_answer", 1, uid_answer);
    chk("uid_answer_value", r_uid[0], uid_answer_value);
    complete_run;
  end
endmodule : transfer_completion_tracker_test
